// ---- design/dcfm_pkg.sv ----
// shared constants of the dual-port fifo with mailboxes
// assumes: dcfm_top in design/ and the bench in tb/ use it, always by scoped name
package dcfm_pkg;

  // ---------------------------------------------------------------
  // data path shape
  // ---------------------------------------------------------------
  localparam int DATA_W      = 36;   // width of both port buses and mailboxes
  localparam int DEPTH_DEF   = 512;  // main array depth, 1024 and 2048 also legal
  localparam int STAGE_DEPTH = 16;   // write staging buffer depth

  // ---------------------------------------------------------------
  // offset programming methods, sampled just after reset release
  // ---------------------------------------------------------------
  localparam logic [1:0] OFS_PRESET_LO = 2'h0;
  localparam logic [1:0] OFS_PRESET_HI = 2'h1;
  localparam logic [1:0] OFS_PARALLEL  = 2'h2;
  localparam logic [1:0] OFS_SERIAL    = 2'h3;
  localparam int         PRESET_LO     = 8;    // near-full and near-empty offset
  localparam int         PRESET_HI     = 16;

  // parallel offset load sequence, gray coded along the path
  typedef enum logic [1:0] {
    OFS_WAIT   = 2'h0,
    OFS_SECOND = 2'h1,
    OFS_DONE   = 2'h3
  } dcfm_ofs_t;

endpackage : dcfm_pkg

// ---- design/dcfm_stream_if.sv ----
// valid/ready word stream between the design's own modules
// assumes: one source and one sink, both on the same clock
`timescale 1ns/10ps
interface dcfm_stream_if #(
  parameter int W = 36
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : dcfm_stream_if

// ---- design/dcfm_stage_fifo.sv ----
// small synchronous fifo, width and depth as parameters
// assumes: depth is a power of two; one clock for both sides
`timescale 1ns/10ps
module dcfm_stage_fifo #(
  parameter  int W     = 36,
  parameter  int DEPTH = 16,
  localparam int AW    = $clog2(DEPTH)
) (
  // clock and reset
  input  wire logic    i_clk,
  input  wire logic    i_resetn,
  // fill side and drain side
  dcfm_stream_if.snk   wr_s,
  dcfm_stream_if.src   rd_s,
  // words currently held
  output logic [AW:0]  o_level
);

  // ---------------------------------------------------------------
  // storage and pointers
  // ---------------------------------------------------------------
  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_q, wr_d;
  logic [AW:0]  rd_q, rd_d;
  logic         push;
  logic         pop;

  // extra pointer bit tells full from empty
  assign o_level    = wr_q - rd_q;
  assign wr_s.ready = (o_level != (AW+1)'(DEPTH));
  assign rd_s.valid = (wr_q != rd_q);
  assign rd_s.data  = mem[rd_q[AW-1:0]];
  assign push       = wr_s.valid & wr_s.ready;
  assign pop        = rd_s.valid & rd_s.ready;

  // next pointers
  always_comb begin
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
  end

  // pointer registers
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  // array write, no reset needed on data
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= wr_s.data;
    end
  end

endmodule : dcfm_stage_fifo

// ---- design/dcfm_top.sv ----
// dual-port first-word-fall-through fifo with two mailboxes
// assumes: port clocks arrive as plain inputs sampled on i_clk (10 MHz) and
// toggle no faster than once per i_clk cycle; all inputs synchronous
`timescale 1ns/10ps
module dcfm_top #(
  parameter  int DW     = dcfm_pkg::DATA_W,
  parameter  int DEPTH  = dcfm_pkg::DEPTH_DEF,
  parameter  int SDEPTH = dcfm_pkg::STAGE_DEPTH,
  localparam int AW     = $clog2(DEPTH),
  localparam int SLW    = $clog2(SDEPTH) + 1
) (
  // clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_resetn,
  // port A control
  input  wire logic          i_port_a_clock,
  input  wire logic          i_port_a_select_n,
  input  wire logic          i_port_a_transfer_gate,
  input  wire logic          i_port_a_write,
  input  wire logic          i_port_a_mailbox_sel,
  // port A bus
  input  wire logic [DW-1:0] i_port_a_bus,
  output logic      [DW-1:0] o_port_a_bus,
  output logic               o_port_a_bus_oe,
  // port B control
  input  wire logic          i_port_b_clock,
  input  wire logic          i_port_b_select_n,
  input  wire logic          i_port_b_transfer_gate,
  input  wire logic          i_port_b_read,
  input  wire logic          i_port_b_mailbox_sel,
  input  wire logic          i_retransmit_mode,
  input  wire logic          i_read_from_mark,
  // port B bus
  input  wire logic [DW-1:0] i_port_b_bus,
  output logic      [DW-1:0] o_port_b_bus,
  output logic               o_port_b_bus_oe,
  // offset programming
  input  wire logic [1:0]    i_offset_sel,
  input  wire logic          i_serial_enable_n,
  input  wire logic          i_serial_data,
  // flags
  output logic               o_write_space_flag,
  output logic               o_near_full_flag_n,
  output logic               o_read_valid,
  output logic               o_near_empty_flag_n,
  output logic               o_mail1_flag_n,
  output logic               o_mail2_flag_n
);

  // ---------------------------------------------------------------
  // port edge detection and qualification
  // ---------------------------------------------------------------
  logic a_clk_q, b_clk_q;
  logic a_edge, b_edge, a_qual, b_qual;
  logic a_fifo_wr, a_mb_wr, a_mb_rd;
  logic b_fifo_rd, b_mb_rd, b_mb_wr;

  // select low and gate high qualify an edge
  assign a_edge    = i_port_a_clock & ~a_clk_q;
  assign b_edge    = i_port_b_clock & ~b_clk_q;
  assign a_qual    = a_edge & ~i_port_a_select_n & i_port_a_transfer_gate;
  assign b_qual    = b_edge & ~i_port_b_select_n & i_port_b_transfer_gate;
  assign a_fifo_wr = a_qual & i_port_a_write & ~i_port_a_mailbox_sel;
  assign a_mb_wr   = a_qual & i_port_a_write & i_port_a_mailbox_sel;
  assign a_mb_rd   = a_qual & ~i_port_a_write & i_port_a_mailbox_sel;
  assign b_fifo_rd = b_qual & i_port_b_read & ~i_port_b_mailbox_sel;
  assign b_mb_rd   = b_qual & i_port_b_read & i_port_b_mailbox_sel;
  assign b_mb_wr   = b_qual & ~i_port_b_read & i_port_b_mailbox_sel;

  // previous clock levels
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      a_clk_q <= 1'b1;
      b_clk_q <= 1'b1;
    end else begin
      a_clk_q <= i_port_a_clock;
      b_clk_q <= i_port_b_clock;
    end
  end

  // ---------------------------------------------------------------
  // offset programming
  // ---------------------------------------------------------------
  logic               started_q, started_d;
  logic [1:0]         method_q, method_d;
  dcfm_pkg::dcfm_ofs_t ofs_q, ofs_d;
  logic [AW-1:0]      x_q, x_d, y_q, y_d;
  logic [AW:0]        ser_cnt_q, ser_cnt_d;
  logic               ofs_done;

  assign ofs_done = (ofs_q == dcfm_pkg::OFS_DONE);

  // method strap caught in the first cycle after reset release
  always_comb begin
    started_d = 1'b1;
    method_d  = started_q ? method_q : i_offset_sel;
    ofs_d     = ofs_q;
    x_d       = x_q;
    y_d       = y_q;
    ser_cnt_d = ser_cnt_q;
    if (!started_q) begin
      case (i_offset_sel)
        dcfm_pkg::OFS_PRESET_LO: begin
          x_d   = AW'(dcfm_pkg::PRESET_LO);
          y_d   = AW'(dcfm_pkg::PRESET_LO);
          ofs_d = dcfm_pkg::OFS_DONE;
        end
        dcfm_pkg::OFS_PRESET_HI: begin
          x_d   = AW'(dcfm_pkg::PRESET_HI);
          y_d   = AW'(dcfm_pkg::PRESET_HI);
          ofs_d = dcfm_pkg::OFS_DONE;
        end
        default: ofs_d = dcfm_pkg::OFS_WAIT;
      endcase
    end else if (!ofs_done && method_q == dcfm_pkg::OFS_PARALLEL && a_fifo_wr) begin
      // first port-A write loads near-empty, second near-full
      case (ofs_q)
        dcfm_pkg::OFS_WAIT: begin
          x_d   = i_port_a_bus[AW-1:0];
          ofs_d = dcfm_pkg::OFS_SECOND;
        end
        dcfm_pkg::OFS_SECOND: begin
          y_d   = i_port_a_bus[AW-1:0];
          ofs_d = dcfm_pkg::OFS_DONE;
        end
        default: ofs_d = ofs_q;
      endcase
    end else if (!ofs_done && method_q == dcfm_pkg::OFS_SERIAL
                 && a_edge && !i_serial_enable_n) begin
      // near-full msb enters first, near-empty lsb last
      {y_d, x_d} = {y_q[AW-2:0], x_q, i_serial_data};
      ser_cnt_d  = ser_cnt_q + 1'b1;
      if (ser_cnt_q == (AW+1)'(2*AW-1)) begin
        ofs_d = dcfm_pkg::OFS_DONE;
      end
    end
  end

  // offset registers
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      started_q <= 1'b0;
      method_q  <= dcfm_pkg::OFS_PRESET_LO;
      ofs_q     <= dcfm_pkg::OFS_WAIT;
      x_q       <= '0;
      y_q       <= '0;
      ser_cnt_q <= '0;
    end else begin
      started_q <= started_d;
      method_q  <= method_d;
      ofs_q     <= ofs_d;
      x_q       <= x_d;
      y_q       <= y_d;
      ser_cnt_q <= ser_cnt_d;
    end
  end

  // ---------------------------------------------------------------
  // write staging buffer and main array
  // ---------------------------------------------------------------
  dcfm_stream_if #(.W(DW)) st_in ();
  dcfm_stream_if #(.W(DW)) st_out ();
  logic [SLW-1:0] st_level;
  logic [DW-1:0]  mem [DEPTH];
  logic [AW:0]    wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d, mark_q, mark_d, rd_eff;
  logic           ram_room, ram_we, rtm_q, rtm_d;

  // the word in the output register still takes a slot, retransmit keeps from the mark
  assign rd_eff       = rtm_q ? mark_q : rd_ptr_q - (AW+1)'(o_read_valid);
  assign ram_room     = ((wr_ptr_q - rd_eff) != (AW+1)'(DEPTH));
  assign st_out.ready = ram_room;
  assign ram_we       = st_out.valid & ram_room;
  // writes only while the flag shows space and offsets are loaded
  assign st_in.valid  = a_fifo_wr & ofs_done & o_write_space_flag;
  assign st_in.data   = i_port_a_bus;

  dcfm_stage_fifo #(
    .W     (DW),
    .DEPTH (SDEPTH)
  ) u_stage (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .wr_s     (st_in),
    .rd_s     (st_out),
    .o_level  (st_level)
  );

  // array write, order kept by one incrementing pointer
  always_ff @(posedge i_clk) begin
    if (ram_we) begin
      mem[wr_ptr_q[AW-1:0]] <= st_out.data;
    end
  end

  // ---------------------------------------------------------------
  // port-A side flags
  // ---------------------------------------------------------------
  logic [AW:0]   rd_sa0_q, rd_sa0_d, rd_sa1_q, rd_sa1_d;
  logic [AW+1:0] used_a, free_a;
  logic          ws_d, nf_n_d;

  // used words as port A sees them, including the write on this edge
  assign used_a = {1'b0, wr_ptr_q - rd_sa1_q} + (AW+2)'(st_level)
                + (AW+2)'(st_in.valid & st_in.ready);
  assign free_a = (AW+2)'(DEPTH) - used_a;

  // read pointer walks two port-A stages; stale view only under-reports space
  always_comb begin
    rd_sa0_d = rd_sa0_q;
    rd_sa1_d = rd_sa1_q;
    ws_d     = o_write_space_flag;
    nf_n_d   = o_near_full_flag_n;
    wr_ptr_d = ram_we ? wr_ptr_q + 1'b1 : wr_ptr_q;
    if (a_edge) begin
      rd_sa0_d = rd_eff;
      rd_sa1_d = rd_sa0_q;
      ws_d     = ofs_done & (free_a != '0) & st_in.ready;
      nf_n_d   = ~(free_a <= (AW+2)'(y_q));
    end
  end

  // port-A registers, flag low through reset
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      rd_sa0_q           <= '0;
      rd_sa1_q           <= '0;
      wr_ptr_q           <= '0;
      o_write_space_flag <= 1'b0;
      o_near_full_flag_n <= 1'b0;
    end else begin
      rd_sa0_q           <= rd_sa0_d;
      rd_sa1_q           <= rd_sa1_d;
      wr_ptr_q           <= wr_ptr_d;
      o_write_space_flag <= ws_d;
      o_near_full_flag_n <= nf_n_d;
    end
  end

  // ---------------------------------------------------------------
  // port-B side: output register, retransmit, flags
  // ---------------------------------------------------------------
  logic [AW:0]   wr_sb0_q, wr_sb0_d, wr_sb1_q, wr_sb1_d;
  logic [DW-1:0] out_data_q, out_data_d;
  logic          rv_d, ne_n_d, pop_out, ram_avail;
  logic [AW+1:0] used_b;

  assign pop_out   = b_fifo_rd & o_read_valid;
  assign ram_avail = (wr_sb1_q != rd_ptr_q);
  // words left once this edge's pop is done, pointer wrap kept at AW+1 bits
  assign used_b    = {1'b0, wr_sb1_q - rd_ptr_q} + (AW+2)'(o_read_valid & ~pop_out);

  // write pointer walks two port-B stages before a word can fall through
  always_comb begin
    wr_sb0_d   = wr_sb0_q;
    wr_sb1_d   = wr_sb1_q;
    rd_ptr_d   = rd_ptr_q;
    mark_d     = mark_q;
    rtm_d      = rtm_q;
    out_data_d = out_data_q;
    rv_d       = o_read_valid;
    ne_n_d     = o_near_empty_flag_n;
    if (b_edge) begin
      wr_sb0_d = wr_ptr_q;
      wr_sb1_d = wr_sb0_q;
      ne_n_d   = ~(used_b <= (AW+2)'(x_q));
      if (rtm_q && b_qual && i_read_from_mark) begin
        // jump back to the marked word and show it again
        out_data_d = mem[mark_q[AW-1:0]];
        rd_ptr_d   = mark_q + 1'b1;
        rv_d       = 1'b1;
      end else if ((!o_read_valid || pop_out) && ram_avail) begin
        out_data_d = mem[rd_ptr_q[AW-1:0]];
        rd_ptr_d   = rd_ptr_q + 1'b1;
        rv_d       = 1'b1;
      end else if (pop_out) begin
        rv_d = 1'b0;
      end
      if (!i_retransmit_mode) begin
        rtm_d = 1'b0;
      end else if (!rtm_q && o_read_valid) begin
        rtm_d  = 1'b1;
        mark_d = rd_ptr_q - 1'b1;
      end
    end
  end

  // port-B registers
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      wr_sb0_q            <= '0;
      wr_sb1_q            <= '0;
      rd_ptr_q            <= '0;
      mark_q              <= '0;
      rtm_q               <= 1'b0;
      out_data_q          <= '0;
      o_read_valid        <= 1'b0;
      o_near_empty_flag_n <= 1'b0;
    end else begin
      wr_sb0_q            <= wr_sb0_d;
      wr_sb1_q            <= wr_sb1_d;
      rd_ptr_q            <= rd_ptr_d;
      mark_q              <= mark_d;
      rtm_q               <= rtm_d;
      out_data_q          <= out_data_d;
      o_read_valid        <= rv_d;
      o_near_empty_flag_n <= ne_n_d;
    end
  end

  // ---------------------------------------------------------------
  // mailboxes and bus drivers
  // ---------------------------------------------------------------
  logic [DW-1:0] mail1_q, mail1_d, mail2_q, mail2_d;
  logic          mbf1_n_d, mbf2_n_d;
  logic [DW-1:0] a_bus_d, b_bus_d;
  logic          a_oe_d, b_oe_d;

  // a store beats a same-cycle read so new mail is never missed
  always_comb begin
    mail1_d  = a_mb_wr ? i_port_a_bus : mail1_q;
    mail2_d  = b_mb_wr ? i_port_b_bus : mail2_q;
    mbf1_n_d = a_mb_wr ? 1'b0 : (b_mb_rd ? 1'b1 : o_mail1_flag_n);
    mbf2_n_d = b_mb_wr ? 1'b0 : (a_mb_rd ? 1'b1 : o_mail2_flag_n);
    a_bus_d  = i_port_a_mailbox_sel ? mail2_q : '0;
    b_bus_d  = i_port_b_mailbox_sel ? mail1_q : out_data_q;
    a_oe_d   = ~i_port_a_select_n & ~i_port_a_write;
    b_oe_d   = ~i_port_b_select_n & i_port_b_read;
  end

  // drivers follow the pins one i_clk later, a cost of registered outputs
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      mail1_q         <= '0;
      mail2_q         <= '0;
      o_mail1_flag_n  <= 1'b1;
      o_mail2_flag_n  <= 1'b1;
      o_port_a_bus    <= '0;
      o_port_b_bus    <= '0;
      o_port_a_bus_oe <= 1'b0;
      o_port_b_bus_oe <= 1'b0;
    end else begin
      mail1_q         <= mail1_d;
      mail2_q         <= mail2_d;
      o_mail1_flag_n  <= mbf1_n_d;
      o_mail2_flag_n  <= mbf2_n_d;
      o_port_a_bus    <= a_bus_d;
      o_port_b_bus    <= b_bus_d;
      o_port_a_bus_oe <= a_oe_d;
      o_port_b_bus_oe <= b_oe_d;
    end
  end

endmodule : dcfm_top

// ---- tb/dcfm_port_master.sv ----
// port masters' clock source for both sides of the fifo
// assumes: bench samples these clocks on i_clk rising edges
`timescale 1ns/10ps
module dcfm_port_master (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_resetn,
  // continuous port clocks
  output logic      o_port_a_clock,
  output logic      o_port_b_clock
);
  // coincident clocks, so a write and a read can share one edge
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_port_a_clock <= 1'b0;
      o_port_b_clock <= 1'b0;
    end else begin
      o_port_a_clock <= ~o_port_a_clock;
      o_port_b_clock <= ~o_port_b_clock;
    end
  end
endmodule : dcfm_port_master

// ---- tb/dcfm_top_properties.sv ----
// concurrent checks on the ports of dcfm_top, bound below
// assumes: a port edge is a port clock high now and low one i_clk before
`timescale 1ns/10ps
module dcfm_top_properties (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // port controls
  input wire logic i_port_a_clock,
  input wire logic i_port_a_select_n,
  input wire logic i_port_a_transfer_gate,
  input wire logic i_port_a_write,
  input wire logic i_port_a_mailbox_sel,
  input wire logic i_port_b_clock,
  input wire logic i_port_b_select_n,
  // device outputs
  input wire logic o_port_a_bus_oe,
  input wire logic o_port_b_bus_oe,
  input wire logic o_write_space_flag,
  input wire logic o_near_full_flag_n,
  input wire logic o_read_valid,
  input wire logic o_near_empty_flag_n,
  input wire logic o_mail1_flag_n
);
  // --------------------
  // edge helpers
  // --------------------
  logic a_prev_q;
  logic b_prev_q;
  logic run_q;
  logic a_edge;
  logic b_edge;
  logic mail1_wr;
  // previous level resets high, so a clock high at release is no edge
  always_ff @(posedge i_clk) begin
    a_prev_q <= i_resetn ? i_port_a_clock : 1'b1;
    b_prev_q <= i_resetn ? i_port_b_clock : 1'b1;
    run_q    <= i_resetn;
  end
  // raw port edges and the qualified mailbox store they carry
  assign a_edge   = i_port_a_clock & ~a_prev_q;
  assign b_edge   = i_port_b_clock & ~b_prev_q;
  assign mail1_wr = a_edge & ~i_port_a_select_n & i_port_a_transfer_gate
                  & i_port_a_write & i_port_a_mailbox_sel;
  // --------------------
  // properties
  // --------------------
  // first cycle after release still sees reset-era history
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn || !run_q);
  sequence s_b_off;
    i_port_b_select_n ##1 i_port_b_select_n;
  endsequence
  a_space_reset: assert property (disable iff (1'b0) !i_resetn |=>
    !o_write_space_flag && !o_read_valid) else $error("flags not low in reset");
  a_a_release: assert property (i_port_a_select_n |=> !o_port_a_bus_oe)
    else $error("port A bus driven while deselected");
  a_a_drive: assert property (!i_port_a_select_n && !i_port_a_write |=> o_port_a_bus_oe)
    else $error("port A read not driven");
  a_b_release: assert property (s_b_off |-> !o_port_b_bus_oe)
    else $error("port B bus driven while deselected");
  a_space_sync: assert property (!a_edge |=>
    $stable(o_write_space_flag) && $stable(o_near_full_flag_n))
    else $error("port A flag moved off an A edge");
  a_valid_sync: assert property (!b_edge |=>
    $stable(o_read_valid) && $stable(o_near_empty_flag_n))
    else $error("port B flag moved off a B edge");
  a_mail_store: assert property (mail1_wr |=> !o_mail1_flag_n)
    else $error("mail1 flag not set by store");
  a_mail_gated: assert property ($fell(o_mail1_flag_n) |-> $past(mail1_wr))
    else $error("mail1 flag set without qualified store");
endmodule : dcfm_top_properties

bind dcfm_top dcfm_top_properties u_props (
  .i_clk, .i_resetn, .i_port_a_clock, .i_port_a_select_n, .i_port_a_transfer_gate,
  .i_port_a_write, .i_port_a_mailbox_sel, .i_port_b_clock, .i_port_b_select_n,
  .o_port_a_bus_oe, .o_port_b_bus_oe, .o_write_space_flag, .o_near_full_flag_n,
  .o_read_valid, .o_near_empty_flag_n, .o_mail1_flag_n
);

// ---- tb/tb_top.sv ----
// self-checking bench for dcfm_top: mailboxes, fill, drain, retransmit
// assumes: coincident port clocks from dcfm_port_master, preset then parallel strap
`timescale 1ns/10ps
module tb_top;
  // --------------------
  // signals
  // --------------------
  localparam int DEPTH = 512;
  localparam int NOFS  = dcfm_pkg::PRESET_LO;
  typedef struct packed {
    logic [35:0] m1_in;
    logic [35:0] m1_out;
    logic [35:0] m2_in;
    logic [35:0] m2_out;
  } dcfm_row_t;
  logic        i_clk    = 1'b0;
  logic        i_resetn = 1'b0;
  logic [3:0]  a_ctl    = 4'h8;   // select_n, gate, write, mailbox
  logic [3:0]  b_ctl    = 4'h4;   // gate, read, mailbox, mark
  logic        b_sel_n  = 1'b0;
  logic        rtm      = 1'b0;
  logic [1:0]  ofs_sel  = 2'h0;
  logic [35:0] a_din    = 36'h0;
  logic [35:0] b_din    = 36'h0;
  logic [35:0] a_dout, b_dout, a_rd, b_rd;
  logic        pa_clk, pb_clk, a_oe, b_oe, ws, nf_n, rv, ne_n, mf1_n, mf2_n;
  int          num_errors  = 0;
  int          checks_done = 0;
  int          n;
  dcfm_row_t   rows [3] = '{
    '{36'h000000000, 36'h000000000, 36'hfffffffff, 36'hfffffffff},
    '{36'h800000001, 36'h800000001, 36'h123456789, 36'h123456789},
    '{36'h5a5a5a5a5, 36'h5a5a5a5a5, 36'ha5a5a5a5a, 36'ha5a5a5a5a}};

  always #50 i_clk = ~i_clk;

  dcfm_port_master u_pm (.i_clk, .i_resetn, .o_port_a_clock(pa_clk), .o_port_b_clock(pb_clk));

  // serial load tied off; the offset strap is driven by the bench
  dcfm_top #(.DEPTH(DEPTH)) u_dut (
    .i_clk, .i_resetn, .i_port_a_clock(pa_clk), .i_port_a_select_n(a_ctl[3]),
    .i_port_a_transfer_gate(a_ctl[2]), .i_port_a_write(a_ctl[1]),
    .i_port_a_mailbox_sel(a_ctl[0]), .i_port_a_bus(a_din), .o_port_a_bus(a_dout),
    .o_port_a_bus_oe(a_oe), .i_port_b_clock(pb_clk), .i_port_b_select_n(b_sel_n),
    .i_port_b_transfer_gate(b_ctl[3]), .i_port_b_read(b_ctl[2]),
    .i_port_b_mailbox_sel(b_ctl[1]), .i_retransmit_mode(rtm), .i_read_from_mark(b_ctl[0]),
    .i_port_b_bus(b_din), .o_port_b_bus(b_dout), .o_port_b_bus_oe(b_oe),
    .i_offset_sel(ofs_sel), .i_serial_enable_n(1'b1), .i_serial_data(1'b0),
    .o_write_space_flag(ws), .o_near_full_flag_n(nf_n), .o_read_valid(rv),
    .o_near_empty_flag_n(ne_n), .o_mail1_flag_n(mf1_n), .o_mail2_flag_n(mf2_n));

  // --------------------
  // helpers
  // --------------------
  function automatic logic [35:0] word(input int k);
    return {4'ha, 32'(k * 7)};
  endfunction : word

  task automatic check(input logic [35:0] seen, input logic [35:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  // returns at the i_clk edge where the port clocks go high
  task automatic to_rise;
    @(posedge i_clk);
    while (pa_clk !== 1'b0) @(posedge i_clk);
  endtask : to_rise

  // hold controls over one port edge, capture the bus just after it
  task automatic a_op(input logic [3:0] c, input logic [35:0] d);
    to_rise();
    a_ctl <= c;
    a_din <= d;
    @(posedge i_clk);
    #1 a_rd = a_dout;
    @(posedge i_clk);
    a_ctl <= 4'h8;
  endtask : a_op

  task automatic b_op(input logic [3:0] c, input logic [35:0] d);
    to_rise();
    b_ctl <= c;
    b_din <= d;
    @(posedge i_clk);
    #1 b_rd = b_dout;
    @(posedge i_clk);
    b_ctl <= 4'h4;
  endtask : b_op

  // --------------------
  // tests
  // --------------------
  initial begin
    #3_000_000;
    num_errors++;
    $display("Error at %0t: watchdog expired", $time);
    wrap_up();
  end

  initial begin
    repeat (20) @(posedge i_clk);
    check({ws, rv, mf1_n, mf2_n, a_oe}, 5'h06, "reset flags");
    i_resetn <= 1'b1;
    repeat (6) @(posedge i_clk);
    check(ws, 1'b1, "space after reset");
    a_op(4'hf, 36'h111111111);
    check({mf1_n, a_oe}, 2'h2, "select high");
    a_op(4'h3, 36'h222222222);
    check(mf1_n, 1'b1, "gate low");
    b_sel_n <= 1'b1;
    repeat (2) @(posedge i_clk);
    check(b_oe, 1'b0, "port B released");
    b_sel_n <= 1'b0;
    $display("test reset and refusals done");
    foreach (rows[i]) begin
      a_op(4'h7, rows[i].m1_in);
      check(mf1_n, 1'b0, "mail1 new");
      b_op(4'he, 36'h0);
      check(b_rd, rows[i].m1_out, "mail1 read");
      check(mf1_n, 1'b1, "mail1 taken");
      b_op(4'ha, rows[i].m2_in);
      check(mf2_n, 1'b0, "mail2 new");
      a_op(4'h5, 36'h0);
      check(a_oe, 1'b1, "mail2 driven");
      check(a_rd, rows[i].m2_out, "mail2 read");
      check(mf2_n, 1'b1, "mail2 taken");
    end
    $display("test mailbox rows done");
    // first word into empty memory: valid on the third B edge after it
    a_op(4'h6, word(0));
    n = 1;
    while (rv !== 1'b1 && n < 20) begin
      @(posedge i_clk);
      n++;
    end
    check(36'(n), 36'h7, "first word latency");
    @(posedge i_clk);
    #1 check(b_dout, word(0), "fall through");
    for (int i = 1; i <= DEPTH; i++) begin
      a_op(4'h6, word(i));
      if (i == DEPTH - NOFS - 2)
        check(nf_n, 1'b1, "near full above offset");
      if (i == DEPTH - NOFS - 1)
        check(nf_n, 1'b0, "near full at offset");
      if (i == DEPTH - 2)
        check(ws, 1'b1, "space before full");
      if (i == DEPTH - 1)
        check(ws, 1'b0, "full");
    end
    check(ne_n, 1'b1, "near empty when full");
    $display("test fill done");
    // the word offered while full must never come out
    for (int i = 0; i < DEPTH; i++) begin
      b_op(4'hc, 36'h0);
      check(b_rd, word(i), "drain order");
      if (i == DEPTH - NOFS - 2)
        check(ne_n, 1'b1, "near empty above offset");
      if (i == DEPTH - NOFS - 1)
        check(ne_n, 1'b0, "near empty at offset");
    end
    repeat (6) @(posedge i_clk);
    check(rv, 1'b0, "empty after drain");
    $display("test drain done");
    for (int i = 600; i < 604; i++) a_op(4'h6, word(i));
    repeat (8) @(posedge i_clk);
    fork
      a_op(4'h6, word(604));
      b_op(4'hc, 36'h0);
    join
    check(b_rd, word(600), "same edge pop");
    to_rise();
    rtm <= 1'b1;
    b_op(4'hc, 36'h0);
    check(b_rd, word(601), "marked word");
    b_op(4'hc, 36'h0);
    check(b_rd, word(602), "after mark");
    b_op(4'h9, 36'h0);
    b_op(4'hc, 36'h0);
    check(b_rd, word(601), "read from mark");
    to_rise();
    rtm <= 1'b0;
    @(posedge i_clk);
    $display("test retransmit done");
    // second reset, parallel strap: two port-A words load the offsets
    ofs_sel  <= dcfm_pkg::OFS_PARALLEL;
    i_resetn <= 1'b0;
    repeat (4) @(posedge i_clk);
    i_resetn <= 1'b1;
    repeat (6) @(posedge i_clk);
    check(ws, 1'b0, "no space before offsets");
    a_op(4'h6, 36'h000000003);
    a_op(4'h6, 36'h000000004);
    repeat (2) @(posedge i_clk);
    check({ws, nf_n}, 2'h3, "space after offsets");
    for (int i = 0; i < 4; i++) a_op(4'h6, word(i));
    repeat (12) @(posedge i_clk);
    check(ne_n, 1'b1, "near empty above loaded offset");
    $display("test offset load done");
    wrap_up();
  end
endmodule : tb_top
